/* File: rtl/sws_pkg.sv */
// Purpose: constants for the section write-staging block
// Assumes: 10 MHz sys_clk, drum timing pulses 10 us apart
// Notes:   phase counts derived from times in ns
package sws_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  // drum timing pulse spacing and fractional offsets, in ns
  localparam int unsigned DTP_SPACING_NS  = 10000;
  localparam int unsigned OFS_SET_NS      = 1200;
  localparam int unsigned OFS_RESET_NS    = 400;
  localparam int unsigned OFS_CLEAR_NS    = 1000;
  localparam int unsigned DTP_SPACING_CYC =
    DTP_SPACING_NS / CLK_PERIOD_NS;
  localparam int unsigned WORD_CYC        = 4 * DTP_SPACING_CYC;
  localparam int unsigned PHASE_W         = $clog2(WORD_CYC);
  // phase of each pulse within the word cycle (pulse 1 at phase 0)
  localparam logic [PHASE_W-1:0] PH_DTP1 = '0;
  localparam logic [PHASE_W-1:0] PH_DTP1_CLR =
    PHASE_W'((OFS_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [PHASE_W-1:0] PH_DTP2 = PHASE_W'(DTP_SPACING_CYC);
  localparam logic [PHASE_W-1:0] PH_DTP2_SET =
    PHASE_W'(DTP_SPACING_CYC
             + (OFS_SET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [PHASE_W-1:0] PH_DTP4 =
    PHASE_W'(3 * DTP_SPACING_CYC);
  localparam logic [PHASE_W-1:0] PH_DTP4_RST =
    PHASE_W'(3 * DTP_SPACING_CYC
             + (OFS_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [PHASE_W-1:0] PH_LAST = PHASE_W'(WORD_CYC - 1);
  // column layout
  localparam int unsigned WORD_W   = 18;
  localparam int unsigned ADDR_N   = 25;
  localparam int unsigned BUSY_N   = 2;
  localparam int unsigned COL_N    = 48;
  localparam int unsigned ROW_N    = 12;
  localparam int unsigned COL_WORD = 0;
  localparam int unsigned COL_ADDR = COL_WORD + WORD_W;
  localparam int unsigned COL_PAR  = COL_ADDR + ADDR_N;
  localparam int unsigned COL_BUSY = COL_PAR + 1;
  // populated section rows
  localparam logic [ROW_N-1:0] ROW_USED = 12'h01F;
  localparam int unsigned ROW_GG_A  = 0;
  localparam int unsigned ROW_GG_B  = 1;
  localparam int unsigned ROW_GATD_A = 2;
  localparam int unsigned ROW_GATD_B = 3;
  localparam int unsigned ROW_TTY   = 4;
  localparam logic [ROW_N-1:0] ROW_RESET_VAL = 12'h000;
  localparam logic [COL_N-1:0] COL_RESET_VAL = 48'h0000_0000_0000;
endpackage : sws_pkg

/* File: rtl/sws_set_driver.sv */
// Purpose: set drivers, gating word, address, parity and busy bits
// Assumes: inputs already synchronous to sys_clk
// Notes:   combinational coincidence of bit and set level
`timescale 1ns/10ps
module sws_set_driver #(
  parameter int unsigned WORD_W = sws_pkg::WORD_W,
  parameter int unsigned ADDR_N = sws_pkg::ADDR_N
) (
  // level inputs
  input  wire logic              set_level,
  input  wire logic [WORD_W-1:0] right_word,
  input  wire logic [ADDR_N-1:0] reg_addr_onehot,
  input  wire logic              out_parity,
  // column drive
  output logic [sws_pkg::COL_N-1:0] col_drive
);
  logic [sws_pkg::COL_N-1:0] raw;
  always_comb begin
    raw = '0;
    raw[sws_pkg::COL_WORD +: WORD_W] = right_word;
    raw[sws_pkg::COL_ADDR +: ADDR_N] = reg_addr_onehot;
    raw[sws_pkg::COL_PAR]            = out_parity;
    raw[sws_pkg::COL_BUSY +: sws_pkg::BUSY_N] = 2'h3;
    col_drive = set_level ? raw : '0;
  end
endmodule : sws_set_driver

/* File: rtl/sws_section_write_staging.sv */
// Purpose: stage one accepted drum word into the selected section row
// Assumes: read-in control gives a one-cycle accept with section select
// Notes:   storage arrays live outside; transfer_valid_q pulses on reset
//          words arriving while a word is in flight are dropped
//          section select is narrowed to one populated row
//          column drive stops at pulse 4 together with the inhibit
`timescale 1ns/10ps
// Overview of operation
// - set driver outputs only with set pulse
// - set pulse adds two busy one bits
// - one-hot address lines for registers 0..24
// - columns: word, address, parity, busy bits
// - 48 columns, 12 rows, five rows used
// - unselected rows inhibited; ones set selected
// - reset clears cells, moves word to storage
// - inhibit at read-in start; reset after write
// - inhibit driver active only while flip-flop set
// - set window from pulse 2+1.2 to 4
// - inhibit from pulse 2, cleared at 4
// - inhibit window covers the set window
// - reset from pulse 4+0.4 to 1+1
// - all flip-flops cleared at pulse 1+1
module sws_section_write_staging #(
  parameter int unsigned WORD_W = sws_pkg::WORD_W,
  parameter int unsigned ADDR_N = sws_pkg::ADDR_N,
  parameter int unsigned ROW_N  = sws_pkg::ROW_N,
  parameter int unsigned COL_N  = sws_pkg::COL_N
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // read-in control
  input  wire logic              word_accept,
  input  wire logic [ROW_N-1:0]  section_sel,
  input  wire logic [WORD_W-1:0] right_word,
  input  wire logic [ADDR_N-1:0] reg_addr_onehot,
  input  wire logic              out_parity,
  // drum timing strobes
  output logic                   dtp1_q,
  output logic                   dtp2_q,
  output logic                   dtp4_q,
  // staging matrix state
  output logic [COL_N-1:0]       set_driver_q,
  output logic [ROW_N-1:0]       reset_inhibit_driver_q,
  output logic [ROW_N-1:0]       row_reset_q,
  output logic [ROW_N*COL_N-1:0] core_current_driver_q,
  // transfer to section storage
  output logic                   transfer_valid_q,
  output logic [ROW_N-1:0]       transfer_row_q,
  output logic [COL_N-1:0]       transfer_word_q
);
  typedef enum logic [2:0] {
    SWS_IDLE, SWS_INHIBIT, SWS_SET, SWS_GAP, SWS_RESET
  } sws_state_type;

  localparam int unsigned PW = sws_pkg::PHASE_W;

  logic [PW-1:0]      phase_q;
  sws_state_type      state_q;
  logic [ROW_N-1:0]   sel_q;
  logic [WORD_W-1:0]  word_q;
  logic [ADDR_N-1:0]  addr_q;
  logic               par_q;
  logic               pend_q;
  logic               set_level;
  logic [COL_N-1:0]   col_drive;
  logic [COL_N-1:0]   row_cells [ROW_N];
  logic [ROW_N-1:0]   row_take;
  logic [ROW_N-1:0]   row_clear;

  // phase strobes and the sequencer events built on them
  logic               ph_dtp1;
  logic               ph_clr;
  logic               ph_dtp2;
  logic               ph_set;
  logic               ph_dtp4;
  logic               ph_rst;
  logic               ph_last;
  logic               start_word;
  logic               start_reset;

  function automatic logic at_phase(input logic [PW-1:0] p,
                                    input logic [PW-1:0] ref_p);
    at_phase = (p == ref_p);
  endfunction : at_phase

  // keep a single row, so that at most one row escapes the inhibit;
  // the lowest populated select line wins
  function automatic logic [ROW_N-1:0] lowest_row(
    input logic [ROW_N-1:0] v
  );
    logic [ROW_N-1:0] pick;
    pick = '0;
    for (int i = int'(ROW_N) - 1; i >= 0; i--) begin
      if (v[i]) begin
        pick    = '0;
        pick[i] = 1'b1;
      end
    end
    return pick;
  endfunction : lowest_row

  // staged word of the selected row out of the flat cell array
  function automatic logic [COL_N-1:0] pick_row(
    input logic [ROW_N-1:0]       sel,
    input logic [ROW_N*COL_N-1:0] flat
  );
    logic [COL_N-1:0] acc;
    acc = '0;
    for (int i = 0; i < int'(ROW_N); i++) begin
      if (sel[i]) begin
        acc = acc | flat[i*COL_N +: COL_N];
      end
    end
    return acc;
  endfunction : pick_row

  // phase strobes, decoded once; every window edge of the word cycle
  // falls on one of these clock edges
  always_comb begin
    ph_dtp1     = at_phase(phase_q, sws_pkg::PH_DTP1);
    ph_clr      = at_phase(phase_q, sws_pkg::PH_DTP1_CLR);
    ph_dtp2     = at_phase(phase_q, sws_pkg::PH_DTP2);
    ph_set      = at_phase(phase_q, sws_pkg::PH_DTP2_SET);
    ph_dtp4     = at_phase(phase_q, sws_pkg::PH_DTP4);
    ph_rst      = at_phase(phase_q, sws_pkg::PH_DTP4_RST);
    ph_last     = at_phase(phase_q, sws_pkg::PH_LAST);
    start_word  = (state_q == SWS_IDLE) && pend_q && ph_dtp2;
    start_reset = (state_q == SWS_GAP) && ph_rst;
  end

  // word cycle phase counter and drum timing strobes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase_q <= '0;
    end else if (ph_last) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dtp1_q <= 1'b0;
      dtp2_q <= 1'b0;
      dtp4_q <= 1'b0;
    end else begin
      dtp1_q <= ph_dtp1;
      dtp2_q <= ph_dtp2;
      dtp4_q <= ph_dtp4;
    end
  end

  // capture an accepted word; accepts while a word is in flight are
  // dropped, and the select is narrowed to one populated row
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_q <= 1'b0;
      sel_q  <= '0;
      word_q <= '0;
      addr_q <= '0;
      par_q  <= 1'b0;
    end else if (word_accept && state_q == SWS_IDLE) begin
      pend_q <= 1'b1;
      sel_q  <= lowest_row(section_sel & sws_pkg::ROW_USED);
      word_q <= right_word;
      addr_q <= reg_addr_onehot;
      par_q  <= out_parity;
    end else if (state_q == SWS_INHIBIT) begin
      pend_q <= 1'b0;
    end
  end

  // sequencer over the word cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= SWS_IDLE;
    end else begin
      case (state_q)
        SWS_IDLE: begin
          if (start_word) begin
            state_q <= SWS_INHIBIT;
          end
        end
        SWS_INHIBIT: begin
          if (ph_set) begin
            state_q <= SWS_SET;
          end
        end
        SWS_SET: begin
          if (ph_dtp4) begin
            state_q <= SWS_GAP;
          end
        end
        SWS_GAP: begin
          if (ph_rst) begin
            state_q <= SWS_RESET;
          end
        end
        SWS_RESET: begin
          if (ph_clr) begin
            state_q <= SWS_IDLE;
          end
        end
        default: state_q <= SWS_IDLE;
      endcase
    end
  end

  // set level only inside the inhibit window, so inhibit covers it
  assign set_level = (state_q == SWS_SET);

  sws_set_driver #(
    .WORD_W (WORD_W),
    .ADDR_N (ADDR_N)
  ) u_set_driver (
    .set_level       (set_level),
    .right_word      (word_q),
    .reg_addr_onehot (addr_q),
    .out_parity      (par_q),
    .col_drive       (col_drive)
  );

  // column drive stops at pulse 4, when the inhibit flip-flops drop, so
  // no set current reaches a row whose inhibit has already ended
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      set_driver_q <= sws_pkg::COL_RESET_VAL;
    end else if (ph_dtp4) begin
      set_driver_q <= sws_pkg::COL_RESET_VAL;
    end else begin
      set_driver_q <= col_drive;
    end
  end

  // inhibit flip-flops: unselected rows from pulse 2 to pulse 4; the
  // selected row's flip-flop is never set
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reset_inhibit_driver_q <= sws_pkg::ROW_RESET_VAL;
    end else if (start_word) begin
      reset_inhibit_driver_q <= ~sel_q;
    end else if (ph_dtp4) begin
      reset_inhibit_driver_q <= sws_pkg::ROW_RESET_VAL;
    end else if (ph_clr) begin
      reset_inhibit_driver_q <= sws_pkg::ROW_RESET_VAL;
    end
  end

  // reset flip-flop of the selected row, pulse 4+0.4 to pulse 1+1; the
  // cells of that row clear one cycle after it rises
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      row_reset_q <= sws_pkg::ROW_RESET_VAL;
    end else if (start_reset) begin
      row_reset_q <= sel_q;
    end else if (ph_clr) begin
      row_reset_q <= sws_pkg::ROW_RESET_VAL;
    end
  end

  // staging cells: a row takes ones only while not inhibited
  genvar r;
  generate
    for (r = 0; r < ROW_N; r++) begin : g_row
      // a row takes ones only while its inhibit driver is idle
      assign row_take[r]  = !reset_inhibit_driver_q[r] &&
                            sws_pkg::ROW_USED[r];
      assign row_clear[r] = row_reset_q[r];
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          row_cells[r] <= sws_pkg::COL_RESET_VAL;
        end else if (row_clear[r]) begin
          row_cells[r] <= sws_pkg::COL_RESET_VAL;
        end else if (row_take[r]) begin
          row_cells[r] <= row_cells[r] | set_driver_q;
        end
      end
      assign core_current_driver_q[r*COL_N +: COL_N] = row_cells[r];
    end
  endgenerate

  // reset edge moves the staged word to the section's storage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      transfer_valid_q <= 1'b0;
      transfer_row_q   <= sws_pkg::ROW_RESET_VAL;
      transfer_word_q  <= sws_pkg::COL_RESET_VAL;
    end else begin
      transfer_valid_q <= start_reset;
      transfer_row_q   <= sel_q;
      transfer_word_q  <= pick_row(sel_q, core_current_driver_q);
    end
  end
endmodule : sws_section_write_staging

/* File: verif/sws_section_write_staging_assertions.sv */
// Purpose: port checks for the section write-staging block
// Assumes: bound to the top module, one clock domain
// Notes:   window checks allow ranges, 100 to 110 cycles for the reset clear
`timescale 1ns/10ps
module sws_chk #(
  parameter int unsigned ROW_N = 12,
  parameter int unsigned COL_N = 48
) (
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rst,
  // timing strobes
  input wire logic                   dtp1_q,
  input wire logic                   dtp2_q,
  input wire logic                   dtp4_q,
  // staging matrix
  input wire logic [COL_N-1:0]       set_driver_q,
  input wire logic [ROW_N-1:0]       reset_inhibit_driver_q,
  input wire logic [ROW_N-1:0]       row_reset_q,
  input wire logic [ROW_N*COL_N-1:0] core_current_driver_q,
  // transfer
  input wire logic                   transfer_valid_q,
  input wire logic [ROW_N-1:0]       transfer_row_q,
  input wire logic [COL_N-1:0]       transfer_word_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_pulse_spacing: assert property (
    dtp1_q |-> ##100 dtp2_q ##200 dtp4_q) else $error("pulse spacing");
  a_busy_bits: assert property (
    |set_driver_q |-> set_driver_q[45:44] == 2'b11) else $error("busy");
  a_spare_cols: assert property (
    set_driver_q[47:46] == 2'b00 && core_current_driver_q[575:240] == '0)
    else $error("unused column or row driven");
  a_addr_onehot: assert property (
    |set_driver_q |-> $onehot(set_driver_q[42:18])) else $error("address");
  a_inhibit_covers: assert property (
    |set_driver_q |-> |reset_inhibit_driver_q) else $error("no inhibit");
  a_inhibit_outlasts: assert property (
    $fell(|reset_inhibit_driver_q) |-> set_driver_q == '0)
    else $error("inhibit ends early");
  a_set_hold: assert property (
    $rose(|set_driver_q) |-> (|set_driver_q)[*8]) else $error("set short");
  a_reset_quiet: assert property (
    |row_reset_q |-> set_driver_q == '0) else $error("data during reset");
  a_transfer_pair: assert property (
    transfer_valid_q |-> transfer_row_q == row_reset_q
      && $onehot(row_reset_q)) else $error("transfer row");
  a_reset_clear: assert property (
    $rose(|row_reset_q) |-> ##[100:110]
      (row_reset_q == '0 && reset_inhibit_driver_q == '0))
    else $error("flops not cleared");
  a_cells_clear: assert property (
    transfer_valid_q |-> ##[1:110] core_current_driver_q == '0)
    else $error("cells not cleared");
endmodule : sws_chk

bind sws_section_write_staging sws_chk #(.ROW_N(ROW_N), .COL_N(COL_N)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .dtp1_q(dtp1_q), .dtp2_q(dtp2_q),
  .dtp4_q(dtp4_q), .set_driver_q(set_driver_q),
  .reset_inhibit_driver_q(reset_inhibit_driver_q),
  .row_reset_q(row_reset_q), .core_current_driver_q(core_current_driver_q),
  .transfer_valid_q(transfer_valid_q), .transfer_row_q(transfer_row_q),
  .transfer_word_q(transfer_word_q));

/* File: verif/sws_readin_model.sv */
// Purpose: read-in control model presenting accepted words
// Assumes: one request at a time, request held until accepted
// Notes:   released lines show the inverse of the last value
`timescale 1ns/10ps
module sws_readin_model (
  // clock and timing
  input  wire logic        sys_clk,
  input  wire logic        dtp1_q,
  // request from bench
  input  wire logic        req,
  input  wire logic [11:0] req_sel,
  input  wire logic [17:0] req_word,
  input  wire logic [24:0] req_addr,
  input  wire logic        req_par,
  // to block
  output logic             word_accept,
  output logic [11:0]      section_sel,
  output logic [17:0]      right_word,
  output logic [24:0]      reg_addr_onehot,
  output logic             out_parity
);
  initial begin
    {word_accept, section_sel, right_word, reg_addr_onehot} = '0;
    out_parity = 1'b0;
  end
  always begin
    @(posedge sys_clk iff req);
    @(posedge sys_clk iff dtp1_q);
    #1;
    word_accept = 1'b1;
    section_sel = req_sel;
    right_word = req_word;
    reg_addr_onehot = req_addr;
    out_parity = req_par;
    @(posedge sys_clk);
    #1;
    word_accept = 1'b0;
    // word held until past pulse 4 + 0.4
    repeat (310) @(posedge sys_clk);
    #1;
    section_sel = ~section_sel;
    right_word = ~right_word;
    reg_addr_onehot = ~reg_addr_onehot;
    out_parity = ~out_parity;
  end
endmodule : sws_readin_model

/* File: verif/section_write_staging_test.sv */
// Purpose: self-checking bench for the section write-staging block
// Assumes: 10 MHz clock, random data from a fixed seed
// Notes:   every used row and both address extremes are staged
`timescale 1ns/10ps
module section_write_staging_test;
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  logic         req = 1'b0;
  logic [11:0]  req_sel = '0;
  logic [17:0]  req_word = '0;
  logic [24:0]  req_addr = '0;
  logic         req_par = 1'b0;
  logic         word_accept, out_parity, dtp1_q, transfer_valid_q;
  logic [11:0]  section_sel, reset_inhibit_driver_q, row_reset_q;
  logic [11:0]  transfer_row_q;
  logic [17:0]  right_word;
  logic [24:0]  reg_addr_onehot;
  logic [47:0]  set_driver_q, transfer_word_q;
  logic [575:0] core_current_driver_q;
  logic [47:0]  exp_q[$];
  int           miscompares = 0;
  int           checked = 0;

  sws_section_write_staging u_sws_section_write_staging (
    .sys_clk(sys_clk), .rst(rst), .word_accept(word_accept),
    .section_sel(section_sel), .right_word(right_word),
    .reg_addr_onehot(reg_addr_onehot), .out_parity(out_parity),
    .dtp1_q(dtp1_q), .dtp2_q(), .dtp4_q(), .set_driver_q(set_driver_q),
    .reset_inhibit_driver_q(reset_inhibit_driver_q),
    .row_reset_q(row_reset_q), .core_current_driver_q(core_current_driver_q),
    .transfer_valid_q(transfer_valid_q), .transfer_row_q(transfer_row_q),
    .transfer_word_q(transfer_word_q));
  sws_readin_model u_sws_readin_model (
    .sys_clk(sys_clk), .dtp1_q(dtp1_q), .req(req), .req_sel(req_sel),
    .req_word(req_word), .req_addr(req_addr), .req_par(req_par),
    .word_accept(word_accept), .section_sel(section_sel),
    .right_word(right_word), .reg_addr_onehot(reg_addr_onehot),
    .out_parity(out_parity));

  initial forever #50 sys_clk = ~sys_clk;

  task automatic chk(input logic [575:0] seen, exp, input string nm);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic run_word(input int r, input int a);
    logic [47:0] e;
    int          n;
    n = 0;
    req_word = 18'($urandom);
    req_addr = 25'h0000001 << a;
    req_par = 1'($urandom);
    req_sel = 12'h001 << r;
    req = 1'b1;
    e = {2'b00, 2'b11, req_par, req_addr, req_word};
    exp_q.push_back(e);
    @(posedge sys_clk iff word_accept);
    #1 req = 1'b0;
    while (!(|set_driver_q) && n++ < 800) tick();
    chk(set_driver_q, e, "set_driver");
    chk(reset_inhibit_driver_q & sws_pkg::ROW_USED,
        ~req_sel & sws_pkg::ROW_USED, "inhibit");
    tick();
    tick();
    chk(core_current_driver_q, 576'(e) << (r * 48), "cells");
    while (transfer_valid_q !== 1'b1 && n++ < 1200) tick();
    chk(core_current_driver_q, 576'(e) << (r * 48), "cells_full");
    chk(transfer_word_q, exp_q.pop_front(), "transfer_word");
    chk(transfer_row_q, req_sel, "transfer_row");
    chk(row_reset_q, req_sel, "row_reset");
    repeat (120) tick();
    chk(core_current_driver_q, '0, "cells_clear");
    chk(row_reset_q | reset_inhibit_driver_q, '0, "flops_clear");
    chk(set_driver_q, '0, "idle_set");
  endtask : run_word

  task automatic test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  initial begin
    #3_000_000;
    miscompares++;
    test_done();
  end

  initial begin
    void'($urandom(32'h893464B0));
    repeat (5) @(posedge sys_clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      run_word(i < 5 ? i : int'($urandom % 5),
               i == 0 ? 0 : i == 1 ? 24 : int'($urandom % 25));
      $display("test %0d done", i);
    end
    test_done();
  end
endmodule : section_write_staging_test
